// ===== msir_regs.v
/*
  modem event status, interrupt mask, line control and software reset
  registers, with interrupt output and fifo flush request.
  assumes a host register port with one-cycle strobes and read data the
  cycle after, and event inputs synchronous to clk.
*/
// Contract
// - writing one to reset bit zero starts a software reset; upper bits reserved.
// - software reset restores all register defaults and empties both fifos.
// - a monitored event sets its status bit to one.
// - sticky bits hold until host writes one; zero leaves them.
// - carrier bit is live, shows carrier only in fsk mode.
// - fifo bits 7..2 follow present rx and tx fifo conditions.
// - inhibitor on and off bits 13 and 14 show present inhibitor state.
// - outside full duplex, clear-to-send only after rts set and no carrier.
// - cts bit 0 read-only; one when cleared in fsk and modulator active.
// - bit 15 sets whenever a reset occurred; sticky until cleared.
// - gap error sets bit 12, parity error bit 10, in fsk mode.
// - bit 11 on fsk frame error or manchester half-bit slip.
// - bit 9 on host watchdog expiry, bit 8 on bad crc.
// - mask bit zero passes event to interrupt; one blocks, status still shows.
// - mask bits 14..0 map to status bits; bit 15 reserved.
// - mask resets to 0x0024, blocking only rx and tx empty.
// - interrupt pin pulses or holds level until status read, per control.
`include "msir_consts.vh"

module msir_regs (
  // clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // register port
  input  wire [7:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  // modem mode and line state
  input  wire        manchester_bus_mode,
  input  wire        carrier_present,
  input  wire        modulator_active,
  input  wire        inhibit_triggered,
  input  wire        inhibit_timeout_expired,
  // error events, one-cycle or longer
  input  wire        gap_error,
  input  wire        frame_error,
  input  wire        half_bit_slip,
  input  wire        parity_error,
  input  wire        host_watchdog_expired,
  input  wire        crc_error,
  // fifo conditions
  input  wire        rx_fifo_at_threshold,
  input  wire        rx_fifo_full,
  input  wire        rx_fifo_empty,
  input  wire        tx_fifo_at_threshold,
  input  wire        tx_fifo_full,
  input  wire        tx_fifo_empty,
  // outputs to modem and host
  output reg         fifo_flush,
  output reg         modem_enable,
  output reg         loopback_enable,
  output reg         clear_to_send,
  output wire        irq_pin
);

  reg  [15:0] mask_q;
  reg  [15:0] lctl_q;
  reg  [15:0] icfg_q;
  reg         swrst_q;
  reg         rst_seen_q;
  wire [15:0] sticky;
  wire [15:0] status;
  wire [15:0] ev_vec;
  wire [15:0] clr_vec;
  wire        fsk_mode;
  wire        wr_status;
  wire        wr_mask;
  wire        wr_lctl;
  wire        wr_icfg;
  wire        wr_swrst;
  wire        cts_now;
  wire        irq_req;

  assign fsk_mode  = ~manchester_bus_mode;
  assign wr_status = reg_wr && (reg_addr == `MSIR_OFS_STATUS);
  assign wr_mask   = reg_wr && (reg_addr == `MSIR_OFS_MASK);
  assign wr_lctl   = reg_wr && (reg_addr == `MSIR_OFS_LINE_CTRL);
  assign wr_icfg   = reg_wr && (reg_addr == `MSIR_OFS_IRQ_CFG);
  assign wr_swrst  = reg_wr && (reg_addr == `MSIR_OFS_SWRST) && reg_wdata[0];

  assign cts_now = lctl_q[`MSIR_LC_RTS] & lctl_q[`MSIR_LC_MOD_EN]
                 & (lctl_q[`MSIR_LC_DUP_EN] | ~carrier_present);

  // event vector into the sticky latches
  assign ev_vec[`MSIR_B_RESET]   = rst_seen_q;
  assign ev_vec[`MSIR_B_INH_OFF] = 1'b0;
  assign ev_vec[`MSIR_B_INH_ON]  = 1'b0;
  // gap and parity in fsk mode
  assign ev_vec[`MSIR_B_GAP]     = gap_error & fsk_mode;
  assign ev_vec[`MSIR_B_FRAME]   = fsk_mode ? frame_error : half_bit_slip;
  assign ev_vec[`MSIR_B_PARITY]  = parity_error & fsk_mode;
  assign ev_vec[`MSIR_B_WDOG]    = host_watchdog_expired;
  assign ev_vec[`MSIR_B_CRC]     = crc_error;
  assign ev_vec[7:0]             = 8'h00;

  assign clr_vec = wr_status ? (reg_wdata & `MSIR_STICKY_MASK) : 16'h0000;

  msir_event_latch #(
    .W (16)
  ) u_latch (
    .clk      (clk),
    .reset_n  (reset_n),
    .flush    (swrst_q),
    .event_in (ev_vec),
    .clear_in (clr_vec),
    .flags    (sticky)
  );

  // live bits merged with sticky ones
  assign status = (sticky & `MSIR_STICKY_MASK)
                | {1'b0, inhibit_timeout_expired, inhibit_triggered, 5'b00000,
                   rx_fifo_at_threshold, rx_fifo_full, rx_fifo_empty,
                   tx_fifo_at_threshold, tx_fifo_full, tx_fifo_empty,
                   carrier_present & fsk_mode,
                   clear_to_send & fsk_mode & modulator_active};

  assign irq_req = |(status & ~mask_q);

  always @(posedge clk) begin
    if (!reset_n || swrst_q) begin
      mask_q  <= `MSIR_RST_MASK;
      lctl_q  <= `MSIR_RST_LINE_CTRL;
      icfg_q  <= `MSIR_RST_IRQ_CFG;
    end else begin
      if (wr_mask) begin
        mask_q <= reg_wdata & `MSIR_MASK_WMASK;
      end
      if (wr_lctl) begin
        lctl_q <= reg_wdata & `MSIR_LCTL_WMASK;
      end
      if (wr_icfg) begin
        icfg_q <= reg_wdata & 16'h000c;
      end
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      swrst_q         <= 1'b0;
      rst_seen_q      <= 1'b1;
      fifo_flush      <= 1'b0;
      modem_enable    <= 1'b0;
      loopback_enable <= 1'b0;
      clear_to_send   <= 1'b0;
      reg_rdata       <= 16'h0000;
    end else begin
      swrst_q         <= wr_swrst;
      rst_seen_q      <= swrst_q;
      fifo_flush      <= wr_swrst;
      modem_enable    <= lctl_q[`MSIR_LC_MOD_EN];
      loopback_enable <= lctl_q[`MSIR_LC_DUP_EN];
      clear_to_send   <= cts_now & ~swrst_q;
      if (reg_rd) begin
        case (reg_addr)
          `MSIR_OFS_STATUS:    reg_rdata <= status;
          `MSIR_OFS_MASK:      reg_rdata <= mask_q;
          `MSIR_OFS_LINE_CTRL: reg_rdata <= lctl_q;
          `MSIR_OFS_IRQ_CFG:   reg_rdata <= icfg_q;
          default:             reg_rdata <= 16'h0000;
        endcase
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end

  msir_irq_gen u_irq (
    .clk         (clk),
    .reset_n     (reset_n),
    .level_mode  (icfg_q[`MSIR_IC_LEVEL]),
    .active_high (icfg_q[`MSIR_IC_POL]),
    .status_read (reg_rd && (reg_addr == `MSIR_OFS_STATUS)),
    .request     (irq_req),
    .irq_pin     (irq_pin)
  );

endmodule // msir_regs

// ===== msir_consts.vh
/*
  shared constants of the modem event status and interrupt register block.
  assumes inclusion by bare name from every design file of the block.
*/
`ifndef MSIR_CONSTS_VH
`define MSIR_CONSTS_VH

// register offsets (word addresses on the plain register port)
`define MSIR_OFS_STATUS     8'h20
`define MSIR_OFS_MASK       8'h21
`define MSIR_OFS_LINE_CTRL  8'h22
`define MSIR_OFS_SWRST      8'h07
`define MSIR_OFS_IRQ_CFG    8'h02

// reset values
`define MSIR_RST_STATUS     16'h0000
`define MSIR_RST_MASK       16'h0024
`define MSIR_RST_LINE_CTRL  16'h0048
`define MSIR_RST_IRQ_CFG    16'h0000

// status bit positions
`define MSIR_B_RESET        15
`define MSIR_B_INH_OFF      14
`define MSIR_B_INH_ON       13
`define MSIR_B_GAP          12
`define MSIR_B_FRAME        11
`define MSIR_B_PARITY       10
`define MSIR_B_WDOG         9
`define MSIR_B_CRC          8
`define MSIR_B_RX_LVL       7
`define MSIR_B_RX_FULL      6
`define MSIR_B_RX_EMPTY     5
`define MSIR_B_TX_LVL       4
`define MSIR_B_TX_FULL      3
`define MSIR_B_TX_EMPTY     2
`define MSIR_B_CARRIER      1
`define MSIR_B_CTS          0

// bits of status that latch until cleared by writing one
`define MSIR_STICKY_MASK    16'h9f00
// writable bits of the mask and line control registers
`define MSIR_MASK_WMASK     16'h7fff
`define MSIR_LCTL_WMASK     16'hf1fd

// line control fields
`define MSIR_LC_MOD_EN      3
`define MSIR_LC_DUP_EN      2
`define MSIR_LC_RTS         0

// interrupt configuration fields
`define MSIR_IC_LEVEL       2
`define MSIR_IC_POL         3

// interrupt pulse counter load for edge-sensitive hosts; the pin pulse lasts one cycle more, 5 cycles
`define MSIR_IRQ_PULSE_CYC  4'h4

`endif

// ===== msir_event_latch.v
/*
  per-bit sticky event latch with write-one-to-clear.
  assumes single clock; events are one or more cycles high.
*/
`include "msir_consts.vh"

module msir_event_latch #(
  parameter W = 16
) (
  // clock and reset
  input  wire         clk,
  input  wire         reset_n,
  input  wire         flush,
  // events and clear
  input  wire [W-1:0] event_in,
  input  wire [W-1:0] clear_in,
  // latched flags
  output wire [W-1:0] flags
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg flag_q;
      always @(posedge clk) begin
        if (!reset_n || flush) begin
          flag_q <= 1'b0;
        end else if (event_in[i]) begin
          flag_q <= 1'b1;
        end else if (clear_in[i]) begin
          flag_q <= 1'b0;
        end
      end
      assign flags[i] = flag_q;
    end
  endgenerate

endmodule // msir_event_latch

// ===== msir_irq_gen.v
/*
  interrupt pin shaper: pulse or held level, selectable polarity.
  assumes request is the or of unmasked status bits.
*/
`include "msir_consts.vh"

module msir_irq_gen (
  // clock and reset
  input  wire clk,
  input  wire reset_n,
  // control
  input  wire level_mode,
  input  wire active_high,
  input  wire status_read,
  // request in, pin out
  input  wire request,
  output reg  irq_pin
);

  reg       req_prev_q;
  reg       held_q;
  reg [3:0] pulse_cnt_q;
  wire      new_req = request & ~req_prev_q;

  always @(posedge clk) begin
    if (!reset_n) begin
      req_prev_q  <= 1'b0;
      held_q      <= 1'b0;
      pulse_cnt_q <= 4'h0;
      irq_pin     <= 1'b1;
    end else begin
      req_prev_q <= request;
      if (new_req) begin
        held_q <= 1'b1;
      end else if (status_read) begin
        held_q <= 1'b0;
      end
      if (new_req) begin
        pulse_cnt_q <= `MSIR_IRQ_PULSE_CYC;
      end else if (pulse_cnt_q != 4'h0) begin
        pulse_cnt_q <= pulse_cnt_q - 4'h1;
      end
      irq_pin <= ~active_high ^ (level_mode ? (held_q | new_req)
                                            : (pulse_cnt_q != 4'h0 || new_req));
    end
  end

endmodule // msir_irq_gen

// ===== msir_host.sv
/*
  host model: drives the register port of the event block.
  assumes callers start just after a rising edge.
*/
module msir_host (
  // register port
  input  wire         clk,
  output logic [7:0]  reg_addr,
  output logic [15:0] reg_wdata,
  output logic        reg_wr,
  output logic        reg_rd,
  input  wire  [15:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 26'h000_0000;
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
endmodule // msir_host

// ===== msir_regs_props.sv
/*
  port assertions of the event register block.
  assumes pulse mode and an active-low interrupt pin.
*/
module msir_regs_props (
  // clock and reset
  input wire        clk,
  input wire        reset_n,
  // register port
  input wire [7:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  // line and outputs
  input wire        carrier_present,
  input wire        fifo_flush,
  input wire        modem_enable,
  input wire        loopback_enable,
  input wire        clear_to_send,
  input wire        irq_pin
);
  wire swrst = reg_wr && reg_addr == 8'h07 && reg_wdata[0];
  wire lctl = reg_wr && reg_addr == 8'h22;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  a_flush_after: assert property (swrst |=> fifo_flush)
    else $error("flush missing");
  a_flush_cause: assert property (fifo_flush |-> $past(swrst))
    else $error("flush without reset write");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read");
  a_cts_carrier: assert property (
    (carrier_present && !loopback_enable) [*2] |-> !clear_to_send)
    else $error("cts with carrier");
  a_cts_modoff: assert property (!modem_enable [*2] |-> !clear_to_send)
    else $error("cts with modem off");
  a_irq_pulse: assert property ($fell(irq_pin) |-> !irq_pin [*5])
    else $error("irq pulse short");
  a_mod_off: assert property (lctl && !reg_wdata[3] |-> ##[1:2] !modem_enable)
    else $error("modem enable stuck");
  a_loop_on: assert property (lctl && reg_wdata[2] |-> ##[1:2] loopback_enable)
    else $error("duplex not set");
  c_flush: cover property (fifo_flush);
  c_irq: cover property ($fell(irq_pin));
  c_cts: cover property ($rose(clear_to_send));
endmodule // msir_regs_props
bind msir_regs msir_regs_props u_msir_regs_props (.*);

// ===== modem_status_irq_regs_tb.sv
/*
  bench of the event register block: table rows, then hand tests.
  assumes msir_host drives the register port.
*/
module modem_status_irq_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        mode = 1'b0;
  logic [5:0]  ev = 6'h00;
  logic [3:0]  ln = 4'h0;
  logic [5:0]  ff = 6'h09;
  logic [7:0]  a;
  logic [15:0] wd, rdata, d;
  logic        wr, rd, irq, cts, ffl, men, lbe;
  int          errors = 0;
  int          comparisons = 0;
  logic [24:0] rows [0:9] = '{{1'b0, 8'h21, 16'h0024}, {1'b0, 8'h22, 16'h0048},
    {1'b0, 8'h20, 16'h8024}, {1'b1, 8'h20, 16'hffff}, {1'b0, 8'h20, 16'h0024},
    {1'b1, 8'h21, 16'hffff}, {1'b1, 8'h55, 16'h1234}, {1'b0, 8'h21, 16'h7fff},
    {1'b0, 8'h07, 16'h0000}, {1'b0, 8'h55, 16'h0000}};
  logic [15:0] ev_exp [0:1][0:5] = '{
    '{16'h0100, 16'h0200, 16'h0400, 16'h0000, 16'h0800, 16'h1000},
    '{16'h0100, 16'h0200, 16'h0000, 16'h0800, 16'h0000, 16'h0000}};
  always #20 clk = ~clk;
  msir_regs u_msir_regs (.clk(clk), .reset_n(reset_n), .reg_addr(a), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .manchester_bus_mode(mode),
    .carrier_present(ln[3]), .modulator_active(ln[2]), .inhibit_triggered(ln[1]),
    .inhibit_timeout_expired(ln[0]), .gap_error(ev[5]), .frame_error(ev[4]),
    .half_bit_slip(ev[3]), .parity_error(ev[2]), .host_watchdog_expired(ev[1]),
    .crc_error(ev[0]), .rx_fifo_at_threshold(ff[5]), .rx_fifo_full(ff[4]),
    .rx_fifo_empty(ff[3]), .tx_fifo_at_threshold(ff[2]), .tx_fifo_full(ff[1]),
    .tx_fifo_empty(ff[0]), .fifo_flush(ffl), .modem_enable(men), .loopback_enable(lbe),
    .clear_to_send(cts), .irq_pin(irq));
  msir_host u_msir_host (.clk(clk), .reg_addr(a), .reg_wdata(wd), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdata));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [15:0] exp);
    u_msir_host.rd(ad, d);
    chk(d, exp);
  endtask
  task automatic pin_is(input logic p, input logic v);
    repeat (2) @(posedge clk);
    #1 chk({15'h0000, p ? irq : cts}, {15'h0000, v});
  endtask
  task automatic report_and_stop;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    chk(rdata, 16'h0000);
    chk({15'h0000, irq}, 16'h0001);
    reset_n <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      if (rows[i][24])
        u_msir_host.wr(rows[i][23:16], rows[i][15:0]);
      else
        rchk(rows[i][23:16], rows[i][15:0]);
    end
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 6; i++) begin
        @(posedge clk);
        mode <= m[0];
        ev <= 6'h01 << i;
        @(posedge clk);
        ev <= 6'h00;
        rchk(8'h20, ev_exp[m][i] | 16'h0024);
        u_msir_host.wr(8'h20, 16'hffff);
      end
    end
    @(posedge clk);
    mode <= 1'b0;
    ev <= 6'h01;
    @(posedge clk);
    ev <= 6'h00;
    u_msir_host.wr(8'h20, 16'h0000);
    rchk(8'h20, 16'h0124);
    chk({15'h0000, irq}, 16'h0001);
    u_msir_host.wr(8'h21, 16'h7eff);
    pin_is(1'b1, 1'b0);
    u_msir_host.wr(8'h20, 16'h0100);
    rchk(8'h20, 16'h0024);
    @(posedge clk);
    ln <= 4'hf;
    ff <= 6'h3f;
    rchk(8'h20, 16'h60fe);
    @(posedge clk);
    ln <= 4'h8;
    ff <= 6'h00;
    mode <= 1'b1;
    rchk(8'h20, 16'h0000);
    @(posedge clk);
    ln <= 4'h4;
    mode <= 1'b0;
    u_msir_host.wr(8'h22, 16'h0049);
    rchk(8'h20, 16'h0001);
    chk({15'h0000, cts}, 16'h0001);
    @(posedge clk);
    ln <= 4'hc;
    pin_is(1'b0, 1'b0);
    u_msir_host.wr(8'h22, 16'h004d);
    pin_is(1'b0, 1'b1);
    chk({15'h0000, lbe}, 16'h0001);
    u_msir_host.wr(8'h22, 16'h0045);
    pin_is(1'b0, 1'b0);
    chk({15'h0000, men}, 16'h0000);
    u_msir_host.wr(8'h07, 16'h0002);
    rchk(8'h21, 16'h7eff);
    u_msir_host.wr(8'h07, 16'h0001);
    #1 chk({15'h0000, ffl}, 16'h0001);
    rchk(8'h21, 16'h0024);
    rchk(8'h22, 16'h0048);
    // carrier still present in fsk mode, so bit 1 reads live
    rchk(8'h20, 16'h8002);
    // level mode: pin held until the status register is read
    @(posedge clk);
    ln <= 4'h0;
    u_msir_host.wr(8'h20, 16'hffff);
    u_msir_host.wr(8'h02, 16'h0004);
    @(posedge clk);
    ev <= 6'h01;
    @(posedge clk);
    ev <= 6'h00;
    repeat (8) @(posedge clk);
    #1 chk({15'h0000, irq}, 16'h0000);
    rchk(8'h20, 16'h0100);
    pin_is(1'b1, 1'b1);
    report_and_stop();
  end
  initial begin
    #100us;
    errors++;
    report_and_stop();
  end
endmodule // modem_status_irq_regs_tb
